// ===== rtl/instr_decoder_consts.svh
`ifndef INSTR_DECODER_CONSTS_SVH
`define INSTR_DECODER_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets on the Avalon-MM slave (byte addresses).
// ----------------------------------------------------------------
`define OFS_INSTR 4'h0
`define OFS_CTRL 4'h4
`define OFS_ACC 4'h8
`define OFS_STATUS 4'hC
// Control register fields.
`define CTRL_PRESC_TIMER 0
`define CTRL_POR 1
// Status register fields.
`define ST_CARRY 0
`define ST_DIGIT_CARRY 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_TIME_OUT 4
`define ST_BUSY 5
// Reset values.
`define ACC_RESET 8'h00
`define DIR_RESET 8'hFF
`define PC_RESET 10'h3FF
// Special file addresses.
`define FILE_TIMER 5'h01
`define FILE_PCL 5'h02
`define FILE_STATUS 5'h03
`define FILE_SECOND_PORT 5'h06
// Timing: oscillator periods per instruction cycle.
`define OSC_PER_CYCLE 4
`define OSC_CNT_LAST 2'h3
`endif

// ===== rtl/instr_decoder_pkg.sv
// ----------------------------------------------------------------
// Types shared by the decoder.
// ----------------------------------------------------------------
package instr_decoder_pkg;
   // Phase of instruction execution.
   typedef enum logic [1:0] {
      PHASE_IDLE = 2'b00,
      PHASE_EXEC = 2'b01,
      PHASE_FLUSH = 2'b10
   } phase_type;
   // Processor status flags.
   typedef struct packed {
      logic time_out;
      logic power_down;
      logic zero;
      logic digit_carry;
      logic carry;
   } flags_type;
   // Request toward the file register array.
   typedef struct packed {
      logic write;
      logic [4:0] addr;
      logic [7:0] data;
   } file_req_type;
endpackage : instr_decoder_pkg

// ===== rtl/instr_decoder.sv
`include "instr_decoder_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module instr_decoder #(
   parameter int FILE_DEPTH = 32 // Number of file registers.
) (
   input wire logic clk_sys, // Oscillator clock, 40 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [3:0] avs_address, // Byte address.
   input wire logic avs_read, // Read strobe.
   input wire logic avs_write, // Write strobe.
   input wire logic [31:0] avs_writedata, // Write data.
   output logic [31:0] avs_readdata, // Read data.
   output logic avs_waitrequest, // Stall of the bus.
   input wire logic [7:0] port_pins, // Sampled second port pin levels.
   output logic [7:0] port_out, // Second port output latch.
   output logic [7:0] port_dir, // Second port tristate latches, 1 = high impedance.
   output logic [9:0] pc, // Program counter.
   output logic prescaler_clear, // One-cycle prescaler clear pulse.
   output logic standby // Processor in standby.
);
   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   // The file array lives here because nothing outside the decoder reaches
   // it; the port, timer and counter cells sit at fixed addresses.
   logic [7:0] files [FILE_DEPTH]; // File register array.
   logic [7:0] acc, next_acc; // Accumulator.
   instr_decoder_pkg::flags_type flags, next_flags; // Status flags.
   instr_decoder_pkg::phase_type phase, next_phase; // Execution phase.
   logic [11:0] instr, next_instr; // Instruction word being executed.
   // Counts the four oscillator periods of one instruction cycle.
   logic [1:0] osc_cnt, next_osc_cnt; // Oscillator period within a cycle.
   logic presc_timer, next_presc_timer; // Prescaler assigned to the timer.
   logic [9:0] next_pc; // Next program counter.
   // Only one return level is kept and no call loads it, so a return
   // always lands on address zero.
   logic [9:0] ret_addr, next_ret_addr; // Single return address.
   logic [7:0] next_port_dir; // Next tristate latches.
   logic next_prescaler_clear; // Next prescaler pulse.
   logic next_standby; // Next standby level.
   logic [31:0] next_readdata; // Next read data.
   logic next_waitrequest; // Next waitrequest.
   instr_decoder_pkg::file_req_type file_req; // File write request.
   // ----------------------------------------------------------------
   // Instruction fields.
   // ----------------------------------------------------------------
   // Fields are sliced straight from the held word; which of them means
   // anything depends on the opcode class being executed.
   logic [4:0] fa; // File address.
   logic dest_file; // Destination select.
   logic [2:0] bit_idx; // Bit index.
   logic [7:0] lit; // Literal.
   logic [7:0] fval; // File operand as read.
   // Both adders always exist; only the add opcode looks at them.
   logic [8:0] sum; // Add result with carry.
   logic [4:0] low_sum; // Low nibble add for digit carry.
   logic [7:0] res; // Byte operation result.
   logic res_valid; // A byte result is produced.
   logic skip; // Following instruction is skipped.
   logic cycle_end; // Last oscillator period of a cycle.
   assign fa = instr[4:0];
   assign dest_file = instr[5];
   assign bit_idx = instr[7:5];
   assign lit = instr[7:0];
   // The fourth period of each cycle is where an instruction commits.
   assign cycle_end = (osc_cnt == `OSC_CNT_LAST);
   // The port is read from its pins so that input-driven bits are not
   // replaced by stale latch contents on write back.
   // The low counter byte is the program counter itself, so it reads from
   // there; no file cell is kept current for it.
   assign fval = (fa == `FILE_SECOND_PORT) ? port_pins :
                 (fa == `FILE_PCL) ? pc[7:0] : files[fa];
   assign sum = {1'b0, acc} + {1'b0, fval};
   assign low_sum = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
   // ----------------------------------------------------------------
   // Execution: computes every next value of the processor state.
   // ----------------------------------------------------------------
   // One process holds bus writes and execution, so their priority is set in
   // one place: execution is evaluated later and wins where both meet.
   always_comb begin
      // Every register except the period count holds by default; the period count steps; pulses and waitrequest fall back to idle.
      next_acc = acc;
      next_flags = flags;
      next_phase = phase;
      next_instr = instr;
      next_pc = pc;
      next_ret_addr = ret_addr;
      next_port_dir = port_dir;
      next_prescaler_clear = 1'b0;
      next_standby = standby;
      next_presc_timer = presc_timer;
      next_readdata = avs_readdata;
      next_waitrequest = 1'b1;
      next_osc_cnt = osc_cnt + 2'h1;
      // No file write and no byte result unless an opcode asks for one.
      file_req = '0;
      res = fval;
      res_valid = 1'b0;
      skip = 1'b0;
      // Bus slave: one wait state, so a request completes two edges after it rises.
      // Read data are captured on every taken access, read or write, and then
      // hold until the next one.
      if ((avs_read || avs_write) && avs_waitrequest) begin
         // Waitrequest drops for exactly one cycle to end the access.
         next_waitrequest = 1'b0;
         case (avs_address)
            `OFS_INSTR: next_readdata = {18'h0, instr, 1'b0,
                                         phase == instr_decoder_pkg::PHASE_IDLE};
            `OFS_CTRL: next_readdata = {31'h0, presc_timer};
            `OFS_ACC: next_readdata = {24'h0, acc};
            `OFS_STATUS: next_readdata = {26'h0, phase != instr_decoder_pkg::PHASE_IDLE,
                                          flags.time_out, flags.power_down, flags.zero,
                                          flags.digit_carry, flags.carry};
            default: next_readdata = 32'h0;
         endcase
         // Only writes change state; a read has no side effect.
         if (avs_write) begin
            // Writes to busy or unmapped offsets are dropped.
            if (avs_address == `OFS_INSTR && phase == instr_decoder_pkg::PHASE_IDLE) begin
               next_instr = avs_writedata[11:0];
               next_phase = instr_decoder_pkg::PHASE_EXEC;
               // The period count restarts so the word gets four full periods.
               next_osc_cnt = 2'h0;
            end else if (avs_address == `OFS_CTRL) begin
               // Prescaler owner, and a power-on event that wakes the core.
               next_presc_timer = avs_writedata[`CTRL_PRESC_TIMER];
               if (avs_writedata[`CTRL_POR]) begin
                  // Both status flags read as set after a power-on event.
                  next_flags.time_out = 1'b1;
                  next_flags.power_down = 1'b1;
                  next_standby = 1'b0;
               end
            end else if (avs_address == `OFS_ACC) begin
               // Accumulator preload; an instruction ending in this cycle wins.
               next_acc = avs_writedata[7:0];
            end
         end
      end
      // Work happens once per four oscillator periods, at the cycle end.
      // The flush cycle stands for the fetch that a branch throws away.
      if (phase == instr_decoder_pkg::PHASE_FLUSH && cycle_end) begin
         next_phase = instr_decoder_pkg::PHASE_IDLE;
      end else if (phase == instr_decoder_pkg::PHASE_EXEC && cycle_end) begin
         next_phase = instr_decoder_pkg::PHASE_IDLE;
         // Default flow steps to the next word.
         next_pc = pc + 10'h1;
         // Operand fields are wildcards, so the match is on the opcode alone; standby and direction load match the whole word.
         casez (instr)
            // Add: carry out of bit seven, digit carry out of bit three.
            12'b0001_11??_????: begin
               res = sum[7:0];
               res_valid = 1'b1;
               next_flags.carry = sum[8];
               next_flags.digit_carry = low_sum[4];
               next_flags.zero = (sum[7:0] == 8'h00);
            end
            // Logic with the file: only the zero flag can move.
            12'b0001_0???_????, 12'b0001_10??_????: begin
               case (instr[7:6])
                  2'b01: res = acc & fval;
                  2'b00: res = acc | fval;
                  default: res = acc ^ fval;
               endcase
               res_valid = 1'b1;
               next_flags.zero = (res == 8'h00);
            end
            // Plain decrement: zero follows the result.
            12'b0000_11??_????: begin
               res = fval - 8'h01;
               res_valid = 1'b1;
               next_flags.zero = (res == 8'h00);
            end
            // Decrement and skip: flags stay, a zero result costs a cycle.
            12'b0010_11??_????: begin
               res = fval - 8'h01;
               res_valid = 1'b1;
               skip = (res == 8'h00);
            end
            // Plain increment: zero follows the result.
            12'b0010_10??_????: begin
               res = fval + 8'h01;
               res_valid = 1'b1;
               next_flags.zero = (res == 8'h00);
            end
            // Increment and skip: flags stay, a zero result costs a cycle.
            12'b0011_11??_????: begin
               res = fval + 8'h01;
               res_valid = 1'b1;
               skip = (res == 8'h00);
            end
            // Rotate left: carry enters bit zero, bit seven leaves to carry.
            12'b0011_01??_????: begin
               res = {fval[6:0], flags.carry};
               res_valid = 1'b1;
               next_flags.carry = fval[7];
            end
            // Rotate right: carry enters bit seven, bit zero leaves to carry.
            12'b0011_00??_????: begin
               res = {flags.carry, fval[7:1]};
               res_valid = 1'b1;
               next_flags.carry = fval[0];
            end
            // Bit clear or set: opcode bit eight is the new bit value.
            12'b0100_????_????, 12'b0101_????_????: begin
               res = fval;
               res[bit_idx] = instr[8];
               file_req = '{write: 1'b1, addr: fa, data: res};
            end
            // Bit tests only skip; nothing is written back.
            12'b0110_????_????: skip = ~fval[bit_idx];
            // Skip when the tested bit is set.
            12'b0111_????_????: skip = fval[bit_idx];
            // Literal logic: the result always lands in the accumulator.
            12'b1110_????_????: begin
               next_acc = acc & lit;
               next_flags.zero = ((acc & lit) == 8'h00);
            end
            // Literal inclusive or.
            12'b1101_????_????: begin
               next_acc = acc | lit;
               next_flags.zero = ((acc | lit) == 8'h00);
            end
            // Literal exclusive or.
            12'b1111_????_????: begin
               next_acc = acc ^ lit;
               next_flags.zero = ((acc ^ lit) == 8'h00);
            end
            // Return: the literal lands in the accumulator and the counter reloads.
            12'b1000_????_????: begin
               next_acc = lit;
               next_pc = {1'b0, ret_addr[8:0]};
               next_phase = instr_decoder_pkg::PHASE_FLUSH;
            end
            // Standby: time-out set, power-down cleared, the standby output rises; execution carries on.
            12'b0000_0000_0011: begin
               next_flags.time_out = 1'b1;
               next_flags.power_down = 1'b0;
               next_standby = 1'b1;
            end
            // Direction load is decoded for the second port's file only.
            12'b0000_0000_0110: next_port_dir = acc;
            // Anything else is a one-cycle no-operation.
            default: ;
         endcase
         // Result routing for byte operations.
         // Bit set and clear build their own request above, so they skip this.
         if (res_valid) begin
            if (dest_file) begin
               file_req = '{write: 1'b1, addr: fa, data: res};
            end else begin
               next_acc = res;
            end
         end
         // A taken skip steps over the next word and spends a flush cycle.
         if (skip) begin
            next_pc = pc + 10'h2;
            next_phase = instr_decoder_pkg::PHASE_FLUSH;
         end
         // A computed write to the low counter byte is a jump.
         // Only the low byte loads; bits eight and nine come back as zero.
         if (file_req.write && file_req.addr == `FILE_PCL) begin
            next_pc = {2'b00, file_req.data};
            next_phase = instr_decoder_pkg::PHASE_FLUSH;
         end
         // Writing the timer restarts its prescaler while the two are paired.
         if (file_req.write && file_req.addr == `FILE_TIMER && presc_timer) begin
            next_prescaler_clear = 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   // Every processor register but the file array and port latch loads its next value here;
   // reset is synchronous, so it only acts on a clock edge.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc <= `ACC_RESET;
         // Power-on: time-out and power-down both read as set.
         flags <= '{time_out: 1'b1, power_down: 1'b1, default: 1'b0};
         phase <= instr_decoder_pkg::PHASE_IDLE;
         instr <= 12'h000;
         osc_cnt <= 2'h0;
         presc_timer <= 1'b0;
         // Execution starts at the top word of program memory.
         pc <= `PC_RESET;
         ret_addr <= 10'h000;
         // All second port pins start as inputs, drivers off.
         port_dir <= `DIR_RESET;
         prescaler_clear <= 1'b0;
         standby <= 1'b0;
         avs_readdata <= 32'h0;
         // The bus stalls while idle; waitrequest only drops to end an access.
         avs_waitrequest <= 1'b1;
      end else begin
         acc <= next_acc;
         flags <= next_flags;
         phase <= next_phase;
         instr <= next_instr;
         osc_cnt <= next_osc_cnt;
         presc_timer <= next_presc_timer;
         pc <= next_pc;
         ret_addr <= next_ret_addr;
         port_dir <= next_port_dir;
         prescaler_clear <= next_prescaler_clear;
         standby <= next_standby;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
      end
   end
   // File array: data only, so it carries no reset.
   // Cells never written read back unknown until software fills them.
   always_ff @(posedge clk_sys) begin
      if (file_req.write) begin
         files[file_req.addr] <= file_req.data;
      end
   end
   // The port output latch mirrors file six.
   // Writes reach both the array cell and this latch; reads come from the pins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_out <= 8'h00;
      end else if (file_req.write && file_req.addr == `FILE_SECOND_PORT) begin
         port_out <= file_req.data;
      end
   end
endmodule : instr_decoder
`default_nettype wire

// ===== testbench/instr_decoder_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the decoder.
// ------------------------------------------------------------
module instr_decoder_monitor (
   input wire logic clk_sys, // Clock.
   input wire logic rst, // Reset.
   input wire logic [3:0] avs_address, // Address.
   input wire logic avs_read, // Read strobe.
   input wire logic avs_write, // Write strobe.
   input wire logic [31:0] avs_readdata, // Read data.
   input wire logic avs_waitrequest, // Stall.
   input wire logic [7:0] port_out, // Output latch.
   input wire logic [7:0] port_dir, // Tristate latches.
   input wire logic [9:0] pc, // Program counter.
   input wire logic prescaler_clear, // Clear pulse.
   input wire logic standby // Standby level.
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic take; // An instruction write is accepted.
   logic [3:0] since; // Cycles since that, saturating.
   logic [3:0] next_since; // Next count.
   assign take = avs_write && avs_waitrequest && avs_address == 4'h0;
   // Side effects must trail an accepted instruction, so count from it.
   always_comb begin
      next_since = since;
      if (take) begin
         next_since = 4'h0;
      end else if (since != 4'hF) begin
         next_since = since + 4'h1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         since <= 4'hF;
      end else begin
         since <= next_since;
      end
   end
   sequence req_pending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence answered;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   bus_answer_a:
      assert property (req_pending |=> answered) else $error("bus answer late");
   reset_state_a:
      assert property (disable iff (1'b0) rst |=> pc == 10'h3FF && port_dir == 8'hFF
         && !standby && !prescaler_clear) else $error("reset state wrong");
   readdata_hold_a:
      assert property ($changed(avs_readdata) |-> ($past(avs_read) || $past(avs_write))
         && !avs_waitrequest) else $error("read data moved");
   pc_bit_nine_a:
      assert property ($changed(pc) |-> !pc[9]) else $error("pc bit nine set");
   dir_load_a:
      assert property ($changed(port_dir) |-> since <= 4'hA) else $error("dir moved");
   out_write_a:
      assert property ($changed(port_out) |-> since <= 4'hA) else $error("out moved");
   presc_pulse_a:
      assert property (prescaler_clear |-> since <= 4'hA ##1 !prescaler_clear)
         else $error("clear pulse wrong");
   standby_entry_a:
      assert property ($rose(standby) |-> since <= 4'hA) else $error("standby stray");
endmodule : instr_decoder_monitor
bind instr_decoder instr_decoder_monitor i_instr_decoder_monitor (.clk_sys, .rst,
   .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .port_out,
   .port_dir, .pc, .prescaler_clear, .standby);
`default_nettype wire

// ===== testbench/program_memory.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Program store: base words and their free operand bits.
// ------------------------------------------------------------
module program_memory (
   input wire logic [4:0] addr, // Entry index, 0 to 18.
   output logic [11:0] word, // Word with free operand bits cleared.
   output logic [11:0] mask // Operand bits that may vary.
);
   // File operands point at the port so operands come from the pins and results show at the latch.
   localparam logic [11:0] WORDS [19] = '{
      12'h1C6, 12'h146, 12'h106, 12'h186,
      12'h0C6, 12'h2C6, 12'h286, 12'h3C6,
      12'h346, 12'h306,
      12'h406, 12'h506, 12'h606, 12'h706,
      12'hE00, 12'hD00, 12'hF00, 12'h800,
      12'h00F};
   // Byte ops vary the destination bit, bit ops the index, literals all eight bits.
   always_comb begin
      word = WORDS[addr];
      mask = addr < 5'h0A ? 12'h020 : addr < 5'h0E ? 12'h0E0 : addr < 5'h12 ? 12'h0FF : 12'h000;
   end
endmodule : program_memory
`default_nettype wire

// ===== testbench/twelve_bit_instruction_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module twelve_bit_instruction_decoder_tb_top;
   // ------------------------------------------------------------
   // Signals and instances.
   // ------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] port_pins = 8'h00;
   logic [7:0] port_out, port_dir;
   logic [9:0] pc;
   logic prescaler_clear, standby;
   logic [4:0] idx = 5'h00;
   logic [11:0] base, mask;
   int err_count = 0;
   int n_checks = 0;
   int n_clr = 0; // Prescaler clear pulses seen.
   program_memory i_program_memory (.addr(idx), .word(base), .mask(mask));
   instr_decoder i_instr_decoder (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .port_pins, .port_out, .port_dir,
      .pc, .prescaler_clear, .standby);
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (prescaler_clear === 1'b1) n_clr++;
   end
   // ------------------------------------------------------------
   // Tasks and reference model.
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One bus cycle; the request is held until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // Runs one word; busy is sampled between the one- and two-cycle end points.
   task automatic ex(input logic [11:0] ins, input logic sk);
      logic [31:0] q;
      bus(1'b1, 4'h0, {20'h0, ins}, q);
      repeat (3) @(posedge clk_sys);
      bus(1'b0, 4'hC, 32'h0, q);
      chk("busy", sk, q[5]);
      while (q[5] !== 1'b0) bus(1'b0, 4'hC, 32'h0, q);
   endtask : ex
   // Returns skip, file write, flags and result for a word on the port file.
   function automatic logic [14:0] model(input logic [11:0] i, input logic [7:0] w,
      input logic [7:0] p, input instr_decoder_pkg::flags_type f);
      logic [8:0] s;
      logic [7:0] r;
      logic sk, z, wr;
      r = w;
      sk = 1'b0;
      z = 1'b1;
      s = 9'(w) + 9'(p);
      casez (i[11:6])
         6'b000111: begin
            r = s[7:0];
            f.carry = s[8];
            f.digit_carry = 5'(w[3:0]) + 5'(p[3:0]) > 5'h0F;
         end
         6'b000101: r = w & p;
         6'b000100: r = w | p;
         6'b000110: r = w ^ p;
         6'b000011: r = p - 8'h01;
         6'b001010: r = p + 8'h01;
         6'b1110??: r = w & i[7:0];
         6'b1101??: r = w | i[7:0];
         6'b1111??: r = w ^ i[7:0];
         default: z = 1'b0;
      endcase
      casez (i[11:6])
         6'b001011: begin r = p - 8'h01; sk = r == 8'h00; end
         6'b001111: begin r = p + 8'h01; sk = r == 8'h00; end
         6'b001101: begin r = {p[6:0], f.carry}; f.carry = p[7]; end
         6'b001100: begin r = {f.carry, p[7:1]}; f.carry = p[0]; end
         6'b0100??: r = p & ~(8'h01 << i[7:5]);
         6'b0101??: r = p | (8'h01 << i[7:5]);
         6'b0110??: sk = !p[i[7:5]];
         6'b0111??: sk = p[i[7:5]];
         6'b1000??: begin r = i[7:0]; sk = 1'b1; end
         default: ;
      endcase
      if (z) f.zero = r == 8'h00;
      wr = (i[11:10] == 2'b00 && i[5]) || i[11:9] == 3'b010;
      return {sk, wr, f, r};
   endfunction : model
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // ------------------------------------------------------------
   // Main sequence and watchdog.
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic [7:0] w, p, eo;
      logic [11:0] ins;
      logic [14:0] r;
      int c;
      q = $urandom(42);
      eo = 8'h00;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, 4'hC, 32'h0, q);
      chk("status", 6'h18, q[5:0]);
      chk("pc", 10'h3FF, pc);
      bus(1'b0, 4'h6, 32'h0, q);
      chk("unmapped", 32'h0, q);
      ex(12'h5E2, 1'b1);
      chk("pc9", 1'b0, pc[9]);
      chk("pc jump", 10'h0FF, pc);
      // First pass takes corner operands, the second holds the port at FF, the third is random.
      for (int n = 0; n < 57; n++) begin
         idx <= 5'(n % 19);
         @(posedge clk_sys);
         w = n < 19 ? 8'hFF : 8'($urandom);
         p = n < 19 ? 8'h01 : n < 38 ? 8'hFF : 8'($urandom);
         ins = base | (12'($urandom) & mask);
         port_pins <= p;
         bus(1'b1, 4'h8, {24'h0, w}, q);
         bus(1'b0, 4'hC, 32'h0, q);
         r = model(ins, w, p, q[4:0]);
         ex(ins, r[14]);
         bus(1'b0, 4'h8, 32'h0, q);
         chk("acc", r[13] ? w : r[7:0], q[7:0]);
         if (r[13]) eo = r[7:0];
         chk("port_out", eo, port_out);
         bus(1'b0, 4'hC, 32'h0, q);
         chk("flags", r[12:8], q[4:0]);
      end
      w = 8'($urandom);
      bus(1'b1, 4'h8, {24'h0, w}, q);
      ex(12'h006, 1'b0);
      chk("port_dir", w, port_dir);
      c = n_clr;
      bus(1'b1, 4'h4, 32'h1, q);
      ex(12'h501, 1'b0);
      chk("clear", c + 1, n_clr);
      bus(1'b1, 4'h4, 32'h0, q);
      ex(12'h501, 1'b0);
      chk("no clear", c + 1, n_clr);
      ex(12'h003, 1'b0);
      bus(1'b0, 4'hC, 32'h0, q);
      chk("standby", 3'b110, {standby, q[4:3]});
      bus(1'b1, 4'h4, 32'h2, q);
      bus(1'b0, 4'hC, 32'h0, q);
      chk("wake", 3'b011, {standby, q[4:3]});
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      finish_test();
   end
endmodule : twelve_bit_instruction_decoder_tb_top
`default_nettype wire
